// *** pin_mux_pkg.sv ***
//
// ---------------------------------------------------------------------------
// Behaviour
// ---------------------------------------------------------------------------
// Behaviour
// - Codes 11 to 15 put the modulator clock, the auxiliary clock and the auxiliary serial clock, enable and data out on the pin.
// - Code 16 puts the phase detector down pulse on the pin and code 17 the up pulse.
// - Code 18 puts the delayed sigma-delta clock on the pin and code 19 the sigma-delta core clock.
// - Codes 20, 21 and 22 put the integer, fractional and auxiliary write strobes on the pin.
// - Codes 23, 24 and 25 put the latch enable, divider reset and seed load strobe on the pin.
// - Codes 26 to 29 are unused and drive a fixed low.
// - Code 30 puts the serial output buffer enable on the pin and code 31 the soft reset.
// - Bit 5 is a read/write test level that drives the pin when the test source is selected.
// - Bit 6 set forces general output data only; clear lets serial read data take the pin during reads.
// - Bit 7 set keeps the pin driver on; clear enables it only during a serial read cycle.
// - Bit 8 clear enables the strong high-side drive; set disables it.
// - Codes 8, 9 and 10 put the reference buffer, reference divider and oscillator divider outputs on the pin.
package pin_mux_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_SOURCES = 4'h8;

    // Control register fields.
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 5;
    localparam int TEST_BIT = 5;
    localparam int FORCE_BIT = 6;
    localparam int KEEP_ON_BIT = 7;
    localparam int HS_OFF_BIT = 8;
    localparam int CTRL_W = 9;

    // Status register fields.
    localparam int ST_PIN_BIT = 0;
    localparam int ST_OE_BIT = 1;
    localparam int ST_HS_BIT = 2;
    localparam int ST_READ_BIT = 3;

    localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

    // Test source selector code.
    localparam logic [SEL_W-1:0] SEL_TEST = 5'h01;

    localparam int NUM_SRC = 32;

endpackage

// *** pin_mux_select.sv ***
`timescale 1ns/100ps
module pin_mux_select (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [pin_mux_pkg::SEL_W-1:0] sel_i,
    input wire logic test_level_i,
    input wire logic [pin_mux_pkg::NUM_SRC-1:0] sources_i,
    output logic general_output_source_o
);
    import pin_mux_pkg::*;

    logic mux_nxt;

    always_comb begin
        mux_nxt = 1'b0;
        case (sel_i)
            SEL_TEST: mux_nxt = test_level_i;
            5'h08, 5'h09, 5'h0A: mux_nxt = sources_i[sel_i];
            5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F: mux_nxt = sources_i[sel_i];
            5'h10, 5'h11: mux_nxt = sources_i[sel_i];
            5'h12, 5'h13: mux_nxt = sources_i[sel_i];
            5'h14, 5'h15, 5'h16: mux_nxt = sources_i[sel_i];
            5'h17, 5'h18, 5'h19: mux_nxt = sources_i[sel_i];
            5'h1A, 5'h1B, 5'h1C, 5'h1D: mux_nxt = 1'b0;
            5'h1E, 5'h1F: mux_nxt = sources_i[sel_i];
            default: mux_nxt = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------------
    // Registered output
    // ---------------------------------------------------------------------
    // Registering costs a cycle of delay but keeps decode glitches off the pin.
    // registered multiplexer
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            general_output_source_o <= 1'b0;
        end else begin
            general_output_source_o <= mux_nxt;
        end
    end

endmodule

// *** pin_driver.sv ***
`timescale 1ns/100ps
module pin_driver (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic general_output_source_i,
    input wire logic serial_read_data_out_i,
    input wire logic serial_read_active_i,
    input wire logic force_general_output_only_i,
    input wire logic pin_driver_keep_on_i,
    input wire logic high_side_drive_off_i,
    output logic pin_o,
    output logic pin_oe_o,
    output logic high_side_en_o
);
    import pin_mux_pkg::*;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_o <= 1'b0;
        end else if (!force_general_output_only_i && serial_read_active_i) begin
            pin_o <= serial_read_data_out_i;
        end else begin
            pin_o <= general_output_source_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_oe_o <= 1'b0;
        end else begin
            pin_oe_o <= pin_driver_keep_on_i | serial_read_active_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            high_side_en_o <= 1'b1;
        end else begin
            high_side_en_o <= ~high_side_drive_off_i;
        end
    end

endmodule

// *** general_output_pin_mux.sv ***
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module general_output_pin_mux (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [pin_mux_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [pin_mux_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [pin_mux_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [pin_mux_pkg::NUM_SRC-1:0] sources_i,
    input wire logic serial_read_data_out_i,
    input wire logic serial_read_active_i,
    output logic lock_detect_serial_out_pin_o,
    output logic lock_detect_serial_out_pin_oe_o,
    output logic high_side_en_o
);
    import pin_mux_pkg::*;

    logic [CTRL_W-1:0] ctrl_r;
    logic ack_r;
    logic gen_out;
    logic [NUM_SRC-1:0] src_snap_r;

    // ---------------------------------------------------------------------
    // Bus handshake
    // ---------------------------------------------------------------------
    // Each access waits one cycle: waitrequest falls in the cycle after the
    // request appears and rises again as soon as the request is taken.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
        end
    end

    // Waitrequest has a flop of its own that always holds the inverse of ack_r.
    // The port then comes straight from a register and cannot glitch.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_r);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r <= CTRL_RESET;
        end else if (avs_write_i && ack_r && avs_address_i == OFS_CTRL) begin
            if (avs_byteenable_i[0]) begin
                ctrl_r[7:0] <= avs_writedata_i[7:0];
            end
            if (avs_byteenable_i[1]) begin
                ctrl_r[8] <= avs_writedata_i[8];
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            src_snap_r <= '0;
        end else begin
            src_snap_r <= sources_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !ack_r) begin
            case (avs_address_i)
                OFS_CTRL: avs_readdata_o <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
                OFS_STATUS: avs_readdata_o <= {28'h0000000, serial_read_active_i,
                    high_side_en_o, lock_detect_serial_out_pin_oe_o,
                    lock_detect_serial_out_pin_o};
                OFS_SOURCES: avs_readdata_o <= src_snap_r;
                default: avs_readdata_o <= '0;
            endcase
        end
    end

    // ---------------------------------------------------------------------
    // Source selection and pin drive
    // ---------------------------------------------------------------------
    // test bit feeds mux
    pin_mux_select u_select (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sel_i(ctrl_r[SEL_LSB +: SEL_W]),
        .test_level_i(ctrl_r[TEST_BIT]),
        .sources_i(sources_i),
        .general_output_source_o(gen_out)
    );

    pin_driver u_driver (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .general_output_source_i(gen_out),
        .serial_read_data_out_i(serial_read_data_out_i),
        .serial_read_active_i(serial_read_active_i),
        .force_general_output_only_i(ctrl_r[FORCE_BIT]),
        .pin_driver_keep_on_i(ctrl_r[KEEP_ON_BIT]),
        .high_side_drive_off_i(ctrl_r[HS_OFF_BIT]),
        .pin_o(lock_detect_serial_out_pin_o),
        .pin_oe_o(lock_detect_serial_out_pin_oe_o),
        .high_side_en_o(high_side_en_o)
    );

endmodule

// *** pin_mux_properties.sv ***
`timescale 1ns/100ps
module pin_mux_properties
    import pin_mux_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [pin_mux_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_write_i,
    input wire logic [pin_mux_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic avs_waitrequest_o,
    input wire logic [pin_mux_pkg::NUM_SRC-1:0] sources_i,
    input wire logic serial_read_data_out_i,
    input wire logic serial_read_active_i,
    input wire logic lock_detect_serial_out_pin_o,
    input wire logic lock_detect_serial_out_pin_oe_o,
    input wire logic high_side_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [8:0] ctl_r;
    logic mux_r;
    logic ser;
    wire p = lock_detect_serial_out_pin_o;
    assign ser = serial_read_active_i && !ctl_r[FORCE_BIT];
    // The control word is rebuilt from accepted writes, since it is not visible at the ports.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) ctl_r <= CTRL_RESET;
        else if (avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_CTRL)
            ctl_r <= avs_writedata_i[8:0];
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) mux_r <= 1'b0;
        else if (ctl_r[4:0] == SEL_TEST) mux_r <= ctl_r[TEST_BIT];
        else if (ctl_r[4:0] >= 8 && !(ctl_r[4:0] inside {[26:29]}))
            mux_r <= sources_i[ctl_r[4:0]];
        else mux_r <= 1'b0;
    end
    AST_WAIT_ONE: assert property (
        $rose(avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("write not answered after one wait cycle");
    AST_WAIT_STANDS: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held too long");
    AST_OE: assert property (
        lock_detect_serial_out_pin_oe_o ==
            ($past(ctl_r[KEEP_ON_BIT]) || $past(serial_read_active_i)))
        else $error("pin enable wrong");
    AST_HS: assert property (high_side_en_o == !$past(ctl_r[HS_OFF_BIT]))
        else $error("high side drive wrong");
    AST_SERIAL: assert property (
        $past(ser) |-> p == $past(serial_read_data_out_i))
        else $error("serial data not on pin");
    AST_MUX: assert property (!$past(ser) |-> p == $past(mux_r))
        else $error("selected source not on pin");
    AST_SRC: assert property (
        (!$past(ser) && $past(ctl_r[4:0], 2) inside {[8:25], 30, 31})
            |-> p == $past(sources_i[ctl_r[4:0]], 2))
        else $error("routed source not on pin");
    AST_UNUSED: assert property (
        (!$past(ser) && $past(ctl_r[4:0], 2) inside {[26:29]}) |-> !p)
        else $error("unused code drives pin");
    AST_TEST: assert property (
        (!$past(ser) && $past(ctl_r[4:0], 2) == SEL_TEST) |-> p == $past(ctl_r[TEST_BIT], 2))
        else $error("test level not on pin");
    cover property ($past(ser) && p);
    cover property ($rose(p));
    cover property (!high_side_en_o);
endmodule
bind general_output_pin_mux pin_mux_properties u_props (.*);

// *** pin_host.sv ***
`timescale 1ns/100ps
module pin_host (
    input wire logic clk_i,
    input wire logic pin_i,
    input wire logic oe_i,
    output logic level_o
);
    logic last_r = 1'b0;
    // A released pin reads as the opposite of its last level, so a stale value never passes.
    assign level_o = oe_i ? pin_i : ~last_r;
    always @(posedge clk_i) last_r <= level_o;
endmodule

// *** test_general_output_pin_mux.sv ***
`timescale 1ns/100ps
module test_general_output_pin_mux;
    import pin_mux_pkg::*;
    logic clk = 0, reset_n = 0, rd = 0, wr = 0, serial_read_data_out = 0, act = 0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wd = 32'h0, src = 32'h0, rdat, q, exp_hi;
    logic wreq, pin, oe, hs, lvl;
    int errors = 0, tests_run = 0;
    always #20 clk = ~clk;
    general_output_pin_mux u_dut (.clk_i(clk), .reset_n_i(reset_n), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .sources_i(src),
        .serial_read_data_out_i(serial_read_data_out), .serial_read_active_i(act),
        .lock_detect_serial_out_pin_o(pin), .lock_detect_serial_out_pin_oe_o(oe),
        .high_side_en_o(hs));
    pin_host u_host (.clk_i(clk), .pin_i(pin), .oe_i(oe), .level_o(lvl));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge clk);
        chk({pin, oe, hs}, 3'b001);
        reset_n <= 1'b1;
        // --------
        // Every selector code from 1 to 31, driver kept on so the host sees the pin.
        // --------
        for (int c = 1; c < 32; c++) begin
            src <= 32'h1 << c;
            bus(1'b1, OFS_CTRL, 32'h80 | (c == 1 ? 32'h20 : 32'h0) | 32'(c));
            exp_hi = 32'(c == 1 || (c >= 8 && !(c inside {[26:29]})));
            repeat (3) @(posedge clk);
            chk(lvl, exp_hi);
            src <= ~(32'h1 << c);
            repeat (3) @(posedge clk);
            chk(lvl, 32'(c == 1));
        end
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(q, 32'h9F);
        bus(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h00B);
        src <= 32'h0;
        act <= 1'b1;
        serial_read_data_out <= 1'b1;
        repeat (3) @(posedge clk);
        chk({pin, oe}, 2'b11);
        bus(1'b1, OFS_CTRL, 32'h04B);
        repeat (3) @(posedge clk);
        chk({pin, oe}, 2'b01);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q, 32'hE);
        src <= 32'h5A5A_C3C3;
        bus(1'b0, OFS_SOURCES, 32'h0);
        chk(q, 32'h5A5A_C3C3);
        act <= 1'b0;
        bus(1'b1, OFS_CTRL, 32'h10B);
        repeat (3) @(posedge clk);
        chk({oe, hs}, 2'b00);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({pin, oe, hs}, 3'b001);
        reset_n <= 1'b1;
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(q, 32'h0);
        tally_and_finish();
    end
endmodule
